// File: verilog/tmrcap_pkg.sv
// Package: register map, field positions, reset values and timing counts of the reload timer
`default_nettype none
package tmrcap_pkg;
   // Bus widths
   localparam int unsigned ADDR_W = 4;
   localparam int unsigned DATA_W = 8;
   // Register offsets
   localparam logic [3:0] OFS_CTRL = 4'h0;
   localparam logic [3:0] OFS_CFG = 4'h1;
   localparam logic [3:0] OFS_RLD_LO = 4'h2;
   localparam logic [3:0] OFS_RLD_HI = 4'h3;
   localparam logic [3:0] OFS_CNT_LO = 4'h4;
   localparam logic [3:0] OFS_CNT_HI = 4'h5;
   localparam logic [3:0] OFS_EV_STAT = 4'h6;
   localparam logic [3:0] OFS_EV_CLR = 4'h7;
   localparam logic [3:0] OFS_EV_EN = 4'h8;
   // Control register fields
   localparam int unsigned CTL_HOVF = 7;
   localparam int unsigned CTL_LOVF = 6;
   localparam int unsigned CTL_LIE = 5;
   localparam int unsigned CTL_CEN = 4;
   localparam int unsigned CTL_SPLIT = 3;
   localparam int unsigned CTL_RUN = 2;
   localparam int unsigned CTL_ALT_HI = 1;
   localparam int unsigned CTL_ALT_LO = 0;
   // Configuration register fields
   localparam int unsigned CFG_LSYS = 0;
   localparam int unsigned CFG_HSYS = 1;
   localparam int unsigned CFG_TIE = 2;
   localparam int unsigned CFG_SYNC = 3;
   // Event status bits
   localparam int unsigned EV_HOVF = 0;
   localparam int unsigned EV_LOVF = 1;
   localparam int unsigned EV_CAPT = 2;
   localparam int unsigned EV_WAKE = 3;
   localparam int unsigned EV_W = 4;
   // Reset values
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [2:0] CFG_RST = 3'h0;
   localparam logic [7:0] BYTE_RST = 8'h00;
   localparam logic [3:0] EV_RST = 4'h0;
   localparam logic [7:0] BYTE_MAX = 8'hFF;
   // Alternate clock select codes
   localparam logic [1:0] ALT_DIV12 = 2'h0;
   localparam logic [1:0] ALT_EXT8 = 2'h1;
   localparam logic [1:0] ALT_RSVD = 2'h2;
   localparam logic [1:0] ALT_LFO8 = 2'h3;
   // Timing counts
   localparam logic [3:0] SYS_DIV = 4'hC;
   localparam logic [2:0] SRC_DIV_LAST = 3'h7;
   localparam logic [1:0] SYNC_TICKS = 2'h3;
   // Suspend tracking states
   typedef enum logic [2:0] {
      PWR_RUN = 3'b001,
      PWR_SUSP = 3'b010,
      PWR_SYNC = 3'b100
   } tmrcap_pwr_t;
endpackage
`default_nettype wire

// File: verilog/tmrcap_byte_if.sv
// Interface between the timer core and one 8-bit counter byte
`timescale 1ns/10ps
`default_nettype none
interface tmrcap_byte_if;
   logic inc; // Count one step
   logic load; // Take reload value
   logic [7:0] load_val; // Reload value
   logic wr; // Software write
   logic [7:0] wr_data; // Software data
   logic [7:0] count; // Current count
   logic carry; // Wrap from all ones this cycle
   modport ctl (output inc, output load, output load_val, output wr, output wr_data, input count, input carry);
   modport cnt (input inc, input load, input load_val, input wr, input wr_data, output count, output carry);
endinterface
`default_nettype wire

// File: verilog/tmrcap_byte.sv
// One auto-reload counter byte, used twice by the timer core
`timescale 1ns/10ps
`default_nettype none
module tmrcap_byte
   import tmrcap_pkg::*;
(
   input wire logic clk_i,
   input wire logic reset_n_i,
   tmrcap_byte_if.cnt bus
);
   logic [7:0] count_r; // Counter byte
   logic [7:0] count_nxt; // Next count

   // Software write beats reload, reload beats increment
   always_comb begin
      count_nxt = count_r;
      if (bus.wr) begin
         count_nxt = bus.wr_data;
      end else if (bus.load) begin
         count_nxt = bus.load_val;
      end else if (bus.inc) begin
         count_nxt = count_r + 8'h01;
      end
   end

   // Counter storage
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         count_r <= BYTE_RST;
      end else begin
         count_r <= count_nxt;
      end
   end

   assign bus.count = count_r;
   assign bus.carry = bus.inc && (count_r == BYTE_MAX);
endmodule // tmrcap_byte
`default_nettype wire

// File: verilog/tmrcap_top.sv
// Auto-reload timer with split mode, oscillator capture and suspend wake
`timescale 1ns/10ps
`default_nettype none
module tmrcap_top
   import tmrcap_pkg::*;
(
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic [ADDR_W-1:0] addr_i,
   input wire logic [DATA_W-1:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [DATA_W-1:0] rdata_o,
   input wire logic ext_clk_i,
   input wire logic lfo_i,
   input wire logic suspend_i,
   output logic wake_o,
   output logic irq_o
);
   tmrcap_byte_if lo_if (); // Low byte link
   tmrcap_byte_if hi_if (); // High byte link

   tmrcap_byte u_lo (.clk_i(clk_i), .reset_n_i(reset_n_i), .bus(lo_if.cnt));
   tmrcap_byte u_hi (.clk_i(clk_i), .reset_n_i(reset_n_i), .bus(hi_if.cnt));

   // Source synchronisers and dividers
   logic ext_meta_r, ext_sync_r, ext_prev_r; // External clock chain
   logic lfo_meta_r, lfo_sync_r, lfo_prev_r; // Oscillator chain
   logic [3:0] div12_r, div12_nxt; // System clock prescaler
   logic [2:0] ext8_r, ext8_nxt; // External divide by eight
   logic [2:0] lfo8_r, lfo8_nxt; // Oscillator divide by eight
   logic ext_rise, lfo_rise, lfo_fall; // Edges seen after sync
   logic tick_div12, tick_ext8, tick_lfo8; // One-cycle source ticks
   logic tick_lo, tick_hi; // Per-byte count ticks

   // Register state
   logic [7:0] ctrl_r, ctrl_nxt; // Control register
   logic [2:0] cfg_r, cfg_nxt; // Select bits and timer enable
   logic [7:0] rll_r, rll_nxt; // Low reload
   logic [7:0] rlh_r, rlh_nxt; // High reload
   logic [EV_W-1:0] ev_stat_r, ev_stat_nxt; // Sticky events
   logic [EV_W-1:0] ev_en_r, ev_en_nxt; // Event enables
   logic [EV_W-1:0] ev_set; // Events this cycle
   logic [DATA_W-1:0] rdata_nxt; // Read data next
   logic irq_nxt, wake_nxt; // Output next values
   tmrcap_pwr_t pwr_r, pwr_nxt; // Suspend tracking
   logic [1:0] sync_cnt_r, sync_cnt_nxt; // Ticks since wake

   logic split, run, wide_ovf, cap_ev, sync_pend; // Decoded controls

   // Selects a byte's tick from its system_clock bit and the alternate field
   function automatic logic pick_tick(input logic sys_sel, input logic [1:0] alt,
                                      input logic t12, input logic te, input logic tl);
      logic t;
      t = 1'b0;
      if (sys_sel) begin
         t = 1'b1;
      end else begin
         case (alt)
            ALT_DIV12: t = t12;
            ALT_EXT8: t = te;
            ALT_LFO8: t = tl;
            default: t = 1'b0; // Reserved code never counts
         endcase
      end
      return t;
   endfunction

   // Two flops before any use; the third only remembers the last level
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         ext_meta_r <= 1'b0;
         ext_sync_r <= 1'b0;
         ext_prev_r <= 1'b0;
         lfo_meta_r <= 1'b0;
         lfo_sync_r <= 1'b0;
         lfo_prev_r <= 1'b0;
      end else begin
         ext_meta_r <= ext_clk_i;
         ext_sync_r <= ext_meta_r;
         ext_prev_r <= ext_sync_r;
         lfo_meta_r <= lfo_i;
         lfo_sync_r <= lfo_meta_r;
         lfo_prev_r <= lfo_sync_r;
      end
   end

   assign ext_rise = ext_sync_r && !ext_prev_r;
   assign lfo_rise = lfo_sync_r && !lfo_prev_r;
   assign lfo_fall = !lfo_sync_r && lfo_prev_r;
   assign tick_div12 = (div12_r == SYS_DIV - 4'h1);
   assign tick_ext8 = ext_rise && (ext8_r == SRC_DIV_LAST);
   assign tick_lfo8 = lfo_rise && (lfo8_r == SRC_DIV_LAST);

   // Prescalers; the slow sources stay synchronised in suspend too, one clock only
   always_comb begin
      div12_nxt = tick_div12 ? 4'h0 : div12_r + 4'h1;
      ext8_nxt = ext_rise ? ext8_r + 3'h1 : ext8_r;
      lfo8_nxt = lfo_rise ? lfo8_r + 3'h1 : lfo8_r;
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         div12_r <= 4'h0;
         ext8_r <= 3'h0;
         lfo8_r <= 3'h0;
      end else begin
         div12_r <= div12_nxt;
         ext8_r <= ext8_nxt;
         lfo8_r <= lfo8_nxt;
      end
   end

   assign tick_lo = pick_tick(cfg_r[CFG_LSYS], ctrl_r[1:0], tick_div12, tick_ext8, tick_lfo8);
   assign tick_hi = pick_tick(cfg_r[CFG_HSYS], ctrl_r[1:0], tick_div12, tick_ext8, tick_lfo8);

   assign split = ctrl_r[CTL_SPLIT];
   assign run = ctrl_r[CTL_RUN];
   assign wide_ovf = !split && hi_if.carry;
   assign cap_ev = ctrl_r[CTL_CEN] && lfo_fall;
   assign sync_pend = (pwr_r == PWR_SYNC);

   // Byte steering: 16-bit chains low carry into high, split runs each byte apart
   always_comb begin
      lo_if.wr = wr_i && (addr_i == OFS_CNT_LO);
      hi_if.wr = wr_i && (addr_i == OFS_CNT_HI);
      lo_if.wr_data = wdata_i;
      hi_if.wr_data = wdata_i;
      lo_if.load_val = rll_r;
      hi_if.load_val = rlh_r;
      if (split) begin
         lo_if.inc = tick_lo;
         lo_if.load = lo_if.carry;
         hi_if.inc = run && tick_hi;
         hi_if.load = hi_if.carry;
      end else begin
         lo_if.inc = run && tick_lo;
         hi_if.inc = lo_if.carry;
         lo_if.load = wide_ovf;
         hi_if.load = wide_ovf;
      end
   end

   // Register writes; a hardware set beats a software clear in the same cycle
   always_comb begin
      ctrl_nxt = ctrl_r;
      cfg_nxt = cfg_r;
      rll_nxt = rll_r;
      rlh_nxt = rlh_r;
      ev_en_nxt = ev_en_r;
      ev_stat_nxt = ev_stat_r;
      if (wr_i) begin
         case (addr_i)
            OFS_CTRL: ctrl_nxt = wdata_i;
            OFS_CFG: cfg_nxt = wdata_i[2:0];
            OFS_RLD_LO: rll_nxt = wdata_i;
            OFS_RLD_HI: rlh_nxt = wdata_i;
            OFS_EV_CLR: ev_stat_nxt = ev_stat_r & ~wdata_i[EV_W-1:0];
            OFS_EV_EN: ev_en_nxt = wdata_i[EV_W-1:0];
            default: ctrl_nxt = ctrl_r; // Unmapped writes are dropped
         endcase
      end
      // Flags set only by hardware events, never cleared here
      if (hi_if.carry || cap_ev) begin
         ctrl_nxt[CTL_HOVF] = 1'b1;
      end
      if (lo_if.carry) begin
         ctrl_nxt[CTL_LOVF] = 1'b1;
      end
      // Capture overrides a reload write in the same cycle
      if (cap_ev) begin
         rll_nxt = lo_if.count;
         rlh_nxt = hi_if.count;
      end
      ev_stat_nxt = ev_stat_nxt | ev_set;
   end

   always_comb begin
      ev_set = '0;
      ev_set[EV_HOVF] = hi_if.carry;
      ev_set[EV_LOVF] = lo_if.carry;
      ev_set[EV_CAPT] = cap_ev;
      ev_set[EV_WAKE] = (pwr_r == PWR_SUSP) && hi_if.carry;
   end

   // Timer request follows the flags; event path is independent of it
   always_comb begin
      irq_nxt = (cfg_nxt[CFG_TIE] && ctrl_nxt[CTL_HOVF])
                || (cfg_nxt[CFG_TIE] && ctrl_nxt[CTL_LIE] && ctrl_nxt[CTL_LOVF])
                || (|(ev_stat_nxt & ev_en_nxt));
   end

   // Suspend tracking: wake on overflow, sync window after any other wake
   always_comb begin
      pwr_nxt = pwr_r;
      sync_cnt_nxt = sync_cnt_r;
      wake_nxt = 1'b0;
      case (pwr_r)
         PWR_RUN: begin
            if (suspend_i) begin
               pwr_nxt = PWR_SUSP;
            end
         end
         PWR_SUSP: begin
            wake_nxt = wake_o || hi_if.carry;
            if (!suspend_i) begin
               // A timer wake needs no resync window
               pwr_nxt = wake_o ? PWR_RUN : PWR_SYNC;
               sync_cnt_nxt = 2'h0;
               wake_nxt = 1'b0;
            end
         end
         PWR_SYNC: begin
            if (suspend_i) begin
               pwr_nxt = PWR_SUSP;
            end else if (tick_lo) begin
               sync_cnt_nxt = sync_cnt_r + 2'h1;
               if (sync_cnt_r == SYNC_TICKS - 2'h1) begin
                  pwr_nxt = PWR_RUN;
               end
            end
         end
         default: pwr_nxt = PWR_RUN;
      endcase
   end

   // Read mux, data valid only in the cycle after the strobe
   always_comb begin
      rdata_nxt = '0;
      if (rd_i) begin
         case (addr_i)
            OFS_CTRL: rdata_nxt = ctrl_r;
            OFS_CFG: rdata_nxt = {4'h0, sync_pend, cfg_r};
            OFS_RLD_LO: rdata_nxt = rll_r;
            OFS_RLD_HI: rdata_nxt = rlh_r;
            OFS_CNT_LO: rdata_nxt = lo_if.count;
            OFS_CNT_HI: rdata_nxt = hi_if.count;
            OFS_EV_STAT: rdata_nxt = {4'h0, ev_stat_r};
            OFS_EV_EN: rdata_nxt = {4'h0, ev_en_r};
            default: rdata_nxt = '0; // Clear register and holes read zero
         endcase
      end
   end

   // All control state and outputs
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         ctrl_r <= CTRL_RST;
         cfg_r <= CFG_RST;
         rll_r <= BYTE_RST;
         rlh_r <= BYTE_RST;
         ev_stat_r <= EV_RST;
         ev_en_r <= EV_RST;
         rdata_o <= '0;
         irq_o <= 1'b0;
         wake_o <= 1'b0;
         pwr_r <= PWR_RUN;
         sync_cnt_r <= 2'h0;
      end else begin
         ctrl_r <= ctrl_nxt;
         cfg_r <= cfg_nxt;
         rll_r <= rll_nxt;
         rlh_r <= rlh_nxt;
         ev_stat_r <= ev_stat_nxt;
         ev_en_r <= ev_en_nxt;
         rdata_o <= rdata_nxt;
         irq_o <= irq_nxt;
         wake_o <= wake_nxt;
         pwr_r <= pwr_nxt;
         sync_cnt_r <= sync_cnt_nxt;
      end
   end

   // Checks on mode, reload, flag and wake behaviour
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!reset_n_i);

   logic wr_cnt; // Any software write to a counter byte
   assign wr_cnt = lo_if.wr || hi_if.wr;

   chk_wide_chain: assert property (
      (!split && lo_if.carry && hi_if.count != BYTE_MAX && !wr_cnt)
      |=> (hi_if.count == $past(hi_if.count) + 8'h01 && lo_if.count == 8'h00))
      else $error("16-bit carry did not step the high byte");
   chk_wide_reload: assert property (
      (wide_ovf && !wr_cnt) |=> ({hi_if.count, lo_if.count} == {$past(rlh_r), $past(rll_r)} && ctrl_r[CTL_HOVF]))
      else $error("16-bit overflow did not reload and flag");
   chk_high_irq: assert property (
      (ctrl_r[CTL_HOVF] && cfg_r[CFG_TIE]) |-> irq_o)
      else $error("High flag with timer enable gave no request");
   chk_low_irq: assert property (
      (ctrl_r[CTL_LOVF] && ctrl_r[CTL_LIE] && cfg_r[CFG_TIE]) |-> irq_o)
      else $error("Low flag with low enable gave no request");
   chk_split_reload: assert property (
      (split && lo_if.carry && !lo_if.wr) |=> lo_if.count == $past(rll_r))
      else $error("Split low byte did not reload");
   chk_split_gate: assert property (
      (split && !run && !hi_if.wr) |=> $stable(hi_if.count))
      else $error("Stopped high byte moved in split mode");
   chk_sys_tick: assert property (
      cfg_r[CFG_LSYS] |-> tick_lo)
      else $error("System clock select did not tick every cycle");
   chk_low_flag: assert property (
      lo_if.carry |=> ctrl_r[CTL_LOVF] ##1 ctrl_r[CTL_LOVF] || $past(wr_i && addr_i == OFS_CTRL))
      else $error("Low wrap did not set low flag");
   chk_flag_hold: assert property (
      (ctrl_r[CTL_HOVF] && !(wr_i && addr_i == OFS_CTRL)) |=> ctrl_r[CTL_HOVF])
      else $error("High flag cleared without software");
   chk_wake_ovf: assert property (
      (pwr_r == PWR_SUSP && hi_if.carry && suspend_i) |=> wake_o)
      else $error("Overflow in suspend did not wake");
   chk_sync_bound: assert property (
      (pwr_r == PWR_SYNC && tick_lo && sync_cnt_r == 2'h2 && !suspend_i) |=> pwr_r == PWR_RUN && !sync_pend)
      else $error("Sync window ran past three ticks");
   chk_capture_copy: assert property (
      (cap_ev && !wr_cnt) |=> ({rlh_r, rll_r} == $past({hi_if.count, lo_if.count}) && ctrl_r[CTL_HOVF]))
      else $error("Capture did not copy count or set flag");

   cov_split_wrap: cover property (split && hi_if.carry && lo_if.carry);
   cov_capture: cover property (cap_ev ##1 irq_o);
   cov_wake: cover property (pwr_r == PWR_SUSP ##1 wake_o);
   cov_sync: cover property (pwr_r == PWR_SYNC ##[1:200] pwr_r == PWR_RUN);
endmodule // tmrcap_top
`default_nettype wire

// File: verification/tb_tmrcap_top.sv
// Self-checking bench for the auto-reload timer with capture and suspend wake
`timescale 1ns/10ps
`default_nettype none
module tb_tmrcap_top
   import tmrcap_pkg::*;
;
   logic clk = 1'b0; // 100 MHz system clock
   logic reset_n = 1'b0; // Active-low reset
   logic [3:0] addr = 4'h0; // Register offset
   logic [7:0] wdata = 8'h00; // Write data
   logic wr = 1'b0; // Write strobe
   logic rd = 1'b0; // Read strobe
   logic ext_clk = 1'b0; // External clock pin
   logic low_frequency_oscillator = 1'b0; // Slow oscillator pin
   logic suspend = 1'b0; // Suspend level
   logic [7:0] rdata; // Read data
   logic wake; // Wake request
   logic irq; // Interrupt level
   logic [3:0] div_cnt = 4'h0; // Divider for the slow pins
   int errors = 0; // Mismatches seen
   int comparisons = 0; // Comparisons made
   logic [7:0] v; // Scratch read value
   // Expected low-byte counts over 768 cycles, per alternate source code
   localparam logic [7:0] SRC_EXP [4] = '{8'h40, 8'h0C, 8'h00, 8'h06};

   // Free-running clock
   always #5 clk = ~clk;

   // Slow pins: external rises every 8 cycles, oscillator every 16
   always @(posedge clk) begin
      div_cnt <= div_cnt + 4'h1;
      if (div_cnt[1:0] == 2'h3) begin
         ext_clk <= ~ext_clk;
      end
      if (div_cnt[2:0] == 3'h7) begin
         low_frequency_oscillator <= ~low_frequency_oscillator;
      end
   end

   // Device under test
   tmrcap_top uut (
      .clk_i(clk), .reset_n_i(reset_n), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
      .rdata_o(rdata), .ext_clk_i(ext_clk), .lfo_i(low_frequency_oscillator), .suspend_i(suspend), .wake_o(wake), .irq_o(irq)
   );

   // Verdict and end of run
   task automatic report_and_stop;
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // Exact comparison
   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         errors++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // Window comparison, for counts that drift with bus overhead
   task automatic check_rng(input string name, input logic [7:0] seen, input logic [7:0] lo, input logic [7:0] hi);
      comparisons++;
      if ($isunknown(seen) || seen < lo || seen > hi) begin
         errors++;
         $display("Error %s expected %h..%h seen %h", name, lo, hi, seen);
      end
   endtask

   // One-cycle write
   task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   // One-cycle read; data stand only in the following cycle
   task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask

   // Read and compare
   task automatic chk_rd(input string name, input logic [3:0] a, input logic [7:0] exp);
      logic [7:0] d;
      rd_reg(a, d);
      check(name, d, exp);
   endtask

   // Interrupt level after register updates have landed
   task automatic chk_irq(input logic exp);
      repeat (2) @(posedge clk);
      #1 check("irq", {7'h00, irq}, {7'h00, exp});
   endtask

   // Watchdog sized well above the expected run of about 4000 cycles
   initial begin
      repeat (20000) @(posedge clk);
      errors++;
      report_and_stop();
   end

   // Main sequence
   initial begin
      repeat (5) @(posedge clk);
      reset_n <= 1'b1;
      // Reset values of every register and output
      for (int a = 0; a < 9; a++) begin
         chk_rd("reset reg", a[3:0], 8'h00);
      end
      check("wake", {7'h00, wake}, 8'h00);
      chk_irq(1'b0);
      // Read/write access, read-only sync bit, unmapped place
      wr_reg(OFS_RLD_LO, 8'h5A);
      wr_reg(OFS_RLD_HI, 8'hA5);
      wr_reg(OFS_CFG, 8'h0F);
      wr_reg(4'h9, 8'hFF);
      chk_rd("reload lo", OFS_RLD_LO, 8'h5A);
      chk_rd("reload hi", OFS_RLD_HI, 8'hA5);
      chk_rd("config", OFS_CFG, 8'h07);
      chk_rd("unmapped", 4'h9, 8'h00);
      $display("test registers done");

      // 16-bit wrap reloads, sets the high flag, flags stay until cleared
      wr_reg(OFS_CFG, 8'h05);
      wr_reg(OFS_RLD_LO, 8'h34);
      wr_reg(OFS_RLD_HI, 8'h12);
      wr_reg(OFS_CNT_LO, 8'hF0);
      wr_reg(OFS_CNT_HI, 8'hFF);
      wr_reg(OFS_CTRL, 8'h04);
      repeat (30) @(posedge clk);
      chk_rd("count hi", OFS_CNT_HI, 8'h12);
      chk_rd("control", OFS_CTRL, 8'hC4);
      chk_irq(1'b1);
      repeat (200) @(posedge clk);
      chk_rd("control held", OFS_CTRL, 8'hC4);
      wr_reg(OFS_CTRL, 8'h00);
      chk_rd("control clr", OFS_CTRL, 8'h00);
      chk_irq(1'b0);
      // Low wrap in 16-bit mode interrupts only with the low enable
      wr_reg(OFS_CNT_LO, 8'hF8);
      wr_reg(OFS_CNT_HI, 8'h00);
      wr_reg(OFS_CTRL, 8'h04);
      repeat (20) @(posedge clk);
      chk_rd("control lo wrap", OFS_CTRL, 8'h44);
      chk_irq(1'b0);
      wr_reg(OFS_CTRL, 8'h64);
      chk_irq(1'b1);
      wr_reg(OFS_CTRL, 8'h00);
      $display("test sixteen bit done");

      // Split mode: low byte free-running, run gates the high byte
      wr_reg(OFS_CFG, 8'h07);
      wr_reg(OFS_RLD_LO, 8'h80);
      wr_reg(OFS_RLD_HI, 8'h40);
      wr_reg(OFS_CNT_LO, 8'hF0);
      wr_reg(OFS_CNT_HI, 8'hFF);
      wr_reg(OFS_CTRL, 8'h08);
      repeat (30) @(posedge clk);
      chk_rd("split hi held", OFS_CNT_HI, 8'hFF);
      rd_reg(OFS_CNT_LO, v);
      check_rng("split lo", v, 8'h80, 8'hA8);
      chk_rd("split flags", OFS_CTRL, 8'h48);
      chk_irq(1'b0);
      wr_reg(OFS_CTRL, 8'h0C);
      repeat (10) @(posedge clk);
      rd_reg(OFS_CNT_HI, v);
      check_rng("split hi", v, 8'h40, 8'h50);
      rd_reg(OFS_CTRL, v);
      check("split hi flag", v & 8'hBF, 8'h8C);
      chk_irq(1'b1);
      wr_reg(OFS_CTRL, 8'h28);
      repeat (130) @(posedge clk);
      rd_reg(OFS_CTRL, v);
      check("split lo flag", v & 8'hC0, 8'h40);
      chk_irq(1'b1);
      wr_reg(OFS_CTRL, 8'h00);
      $display("test split done");

      // Every alternate source over a fixed span of 768 cycles
      wr_reg(OFS_CFG, 8'h00);
      for (int s = 0; s < 4; s++) begin
         wr_reg(OFS_CNT_LO, 8'h00);
         wr_reg(OFS_CNT_HI, 8'h00);
         wr_reg(OFS_CTRL, 8'h04 | 8'(s)); // Run with alternate code s; oscillator source still divided by eight
         repeat (768) @(posedge clk);
         wr_reg(OFS_CTRL, 8'(s));
         rd_reg(OFS_CNT_LO, v);
         // Zero expectation must not underflow the window
         check_rng("source count", v, (SRC_EXP[s] == 8'h00) ? 8'h00 : SRC_EXP[s] - 8'h01, SRC_EXP[s] + 8'h01);
      end
      wr_reg(OFS_CTRL, 8'h00);
      $display("test clock sources done");

      // Capture on oscillator falling edge, counter then stopped
      wr_reg(OFS_CFG, 8'h05); // Fast system clock, timer request enabled
      wr_reg(OFS_RLD_LO, 8'h00);
      wr_reg(OFS_RLD_HI, 8'h00);
      wr_reg(OFS_CNT_LO, 8'h00);
      wr_reg(OFS_CNT_HI, 8'h00);
      wr_reg(OFS_CTRL, 8'h14); // Split kept off while capturing
      repeat (50) @(posedge clk);
      wr_reg(OFS_CTRL, 8'h10);
      repeat (50) @(posedge clk);
      chk_rd("capture flag", OFS_CTRL, 8'h90);
      chk_irq(1'b1);
      chk_rd("capture event", OFS_EV_STAT, 8'h07);
      rd_reg(OFS_CNT_LO, v);
      check_rng("count lo", v, 8'h30, 8'h3C);
      rd_reg(OFS_RLD_LO, v);
      check_rng("captured lo", v, 8'h30, 8'h3C);
      chk_rd("captured hi", OFS_RLD_HI, 8'h00);
      wr_reg(OFS_CTRL, 8'h00);
      $display("test capture done");

      // Overflow in suspend wakes, events raise, mask and clear the interrupt
      wr_reg(OFS_EV_CLR, 8'h0F);
      wr_reg(OFS_CNT_LO, 8'hF0);
      wr_reg(OFS_CNT_HI, 8'hFF);
      wr_reg(OFS_CTRL, 8'h04);
      @(posedge clk);
      suspend <= 1'b1;
      for (int k = 0; k < 40 && wake !== 1'b1; k++) begin
         @(posedge clk);
      end
      check("wake", {7'h00, wake}, 8'h01);
      @(posedge clk);
      suspend <= 1'b0;
      repeat (2) @(posedge clk);
      #1 check("wake low", {7'h00, wake}, 8'h00);
      wr_reg(OFS_CTRL, 8'h00);
      chk_rd("events", OFS_EV_STAT, 8'h0B);
      chk_irq(1'b0);
      wr_reg(OFS_EV_EN, 8'h08);
      chk_irq(1'b1);
      wr_reg(OFS_EV_CLR, 8'h0F);
      chk_rd("events clr", OFS_EV_STAT, 8'h00);
      chk_irq(1'b0);
      // Other wake: sync pending for three divide-by-12 ticks
      wr_reg(OFS_CFG, 8'h00);
      @(posedge clk);
      suspend <= 1'b1;
      repeat (5) @(posedge clk);
      suspend <= 1'b0;
      chk_rd("sync set", OFS_CFG, 8'h08);
      repeat (60) @(posedge clk);
      chk_rd("sync clr", OFS_CFG, 8'h00);
      check("wake idle", {7'h00, wake}, 8'h00);
      $display("test suspend done");
      report_and_stop();
   end
endmodule // tb_tmrcap_top
`default_nettype wire
